// ==== mac_tx_pkg.sv ====
package mac_tx_pkg;
  // byte clock 100 MHz, one byte time per cycle
  localparam int unsigned CLK_PERIOD_NS   = 10;
  // min-preamble window after token ready, byte times
  localparam int unsigned MIN_PRE_WIN     = 6;
  // final-frame qualification spans
  localparam int unsigned FINAL_PEND_MIN  = 1;
  localparam int unsigned FINAL_STABLE_MIN = 3;
  // token hold wait (max preamble plus one void), nanoseconds
  localparam int unsigned HOLD_WAIT_NS    = 4160;
  localparam int unsigned HOLD_WAIT_CYC   =
    (HOLD_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // token class encodings
  localparam logic [1:0] CLASS_NONE    = 2'h0;
  localparam logic [1:0] CLASS_CAPTURE = 2'h1;
  localparam logic [1:0] CLASS_ISSUE   = 2'h2;
  // frame end kinds reported to the transmitter
  localparam logic [1:0] END_NONE      = 2'h0;
  localparam logic [1:0] END_NORMAL    = 2'h1;
  localparam logic [1:0] END_SUBST     = 2'h2;
  // reset values
  localparam logic [7:0] BYTE_RST      = 8'h00;
endpackage : mac_tx_pkg

// ==== mac_tx_buf2.sv ====
`timescale 1ns/1ps
// two-entry elastic buffer; registered data out
module mac_tx_buf2 #(
  parameter int unsigned WIDTH = 9
) (
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             flush
);
  logic [WIDTH-1:0] head_reg;   // entry shown at output
  logic [WIDTH-1:0] tail_reg;   // overflow entry
  logic [1:0]       count_reg;  // occupancy 0..2
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  assign in_ready  = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data  = head_reg;

  // occupancy and shifting; flush drops both entries
  always_ff @(posedge clk_sys)
  begin
    if (!rstn || flush)
    begin
      count_reg <= 2'h0;
      head_reg  <= '0;
      tail_reg  <= '0;
    end
    else
    begin
      case ({push, pop})
        2'b10:
        begin
          if (count_reg == 2'h0) head_reg <= in_data;
          else tail_reg <= in_data;
          count_reg <= count_reg + 2'h1;
        end
        2'b01:
        begin
          head_reg  <= tail_reg;
          count_reg <= count_reg - 2'h1;
        end
        2'b11:
        begin
          // full case cannot push, so count is 1 here
          head_reg <= in_data;
        end
        default:
        begin
          count_reg <= count_reg;
        end
      endcase
    end
  end
endmodule : mac_tx_buf2

// ==== mac_tx_qual.sv ====
`timescale 1ns/1ps
// counts consecutive cycles a condition has held, saturating
module mac_tx_qual #(
  parameter int unsigned CW = 3
) (
  input  wire logic          clk_sys,
  input  wire logic          rstn,
  input  wire logic          cond,
  output logic [CW-1:0]      held
);
  // saturating run-length counter, cleared when cond drops
  always_ff @(posedge clk_sys)
  begin
    if (!rstn || !cond)
      held <= '0;
    else if (held != {CW{1'b1}})
      held <= held + {{(CW-1){1'b0}}, 1'b1};
  end
endmodule : mac_tx_qual

// ==== mac_tx_request_handshake.sv ====
`timescale 1ns/1ps
module mac_tx_request_handshake #(
  parameter int unsigned HOLD_CYC = mac_tx_pkg::HOLD_WAIT_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  // requester side, same clock
  input  wire logic       request_pending,
  input  wire logic       send_request,
  input  wire logic       final_frame_flag,
  input  wire logic       last_byte_marker,
  input  wire logic       abort_request,
  input  wire logic [7:0] request_data_bus,
  input  wire logic [3:0] service_class_code,
  output logic            byte_accept,
  output logic [1:0]      current_token_class,
  // transmitter side
  input  wire logic       token_ready_ind,
  input  wire logic       transmit_abort_ind,
  input  wire logic       token_pass_ind,
  output logic            tx_valid,
  input  wire logic       tx_ready,
  output logic [7:0]      tx_byte,
  output logic            tx_last,
  output logic [1:0]      frame_end,
  output logic            min_preamble,
  output logic            token_hold
);
  // frame state machine
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DATA = 3'b010,
    ST_DONE = 3'b100
  } frame_e;
  frame_e state_reg;
  frame_e state_next;

  logic       ready_d_reg;     // token ready, previous cycle
  logic       pend_d_reg;      // pending, previous cycle
  logic [3:0] since_rdy_reg;   // cycles since token ready rose
  logic [3:0] class_d_reg;     // service code last cycle
  logic [12:0] hold_cnt_reg;   // token hold countdown
  logic       accept_reg;      // byte accept flop
  logic [1:0] class_reg;       // token class
  logic [1:0] end_reg;         // end kind pulse
  logic       minpre_reg;      // minimum preamble flag
  logic [2:0] pend_held;       // pending run length
  logic [2:0] stable_held;     // class code stable run
  logic       buf_in_ready;    // buffer room
  logic [8:0] buf_out;         // {last, byte}

  // last is honoured only when its byte is really taken; a full
  // buffer would otherwise end the frame and lose the final byte
  wire honor_last  = accept_reg & buf_in_ready & last_byte_marker;
  // same-cycle tie, last marker wins over abort
  wire honor_abort = abort_request & ~(last_byte_marker & accept_reg);
  wire link_kill   = transmit_abort_ind | token_pass_ind;
  wire rdy_rise    = token_ready_ind & ~ready_d_reg;
  wire pend_rise   = request_pending & ~pend_d_reg;
  wire early_win   = (since_rdy_reg < 4'(mac_tx_pkg::MIN_PRE_WIN));
  wire start_frame = (state_reg == ST_IDLE) & send_request &
                     token_ready_ind & ~abort_request & ~link_kill;
  wire take_byte   = (state_reg == ST_DATA) & accept_reg & buf_in_ready;
  wire final_ok    =
    final_frame_flag & ~send_request &
    (pend_held >= 3'(mac_tx_pkg::FINAL_PEND_MIN)) &
    (stable_held >= 3'(mac_tx_pkg::FINAL_STABLE_MIN));

  // run-length of pending high
  mac_tx_qual #(.CW(3)) u_pend_q (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .cond    (request_pending),
    .held    (pend_held)
  );
  // run-length of class code unchanged
  mac_tx_qual #(.CW(3)) u_stab_q (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .cond    (service_class_code == class_d_reg),
    .held    (stable_held)
  );

  // bytes cross to the transmitter through a two-entry buffer,
  // so a stall there drops no byte taken on byte_accept, but can drop the control byte pushed at start_frame
  mac_tx_buf2 #(.WIDTH(9)) u_buf (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .in_valid  (start_frame | take_byte),
    .in_ready  (buf_in_ready),
    .in_data   ({honor_last & ~start_frame, request_data_bus}),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (buf_out),
    .flush     (link_kill | (honor_abort & (state_reg == ST_DATA)))
  );
  assign tx_byte = buf_out[7:0];
  assign tx_last = buf_out[8];

  // next frame state
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (start_frame) state_next = ST_DATA;
      ST_DATA:
        if (link_kill || honor_abort || honor_last)
          state_next = ST_DONE;
      ST_DONE:
        // wait for requester to drop send before next frame
        if (!send_request) state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  // one byte clock for every counter
  // edge history and timing counters
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      ready_d_reg   <= 1'b0;
      pend_d_reg    <= 1'b0;
      class_d_reg   <= 4'h0;
      since_rdy_reg <= 4'hF;
    end
    else
    begin
      ready_d_reg <= token_ready_ind;
      pend_d_reg  <= request_pending;
      class_d_reg <= service_class_code;
      if (rdy_rise) since_rdy_reg <= 4'h0;
      else if (since_rdy_reg != 4'hF)
        since_rdy_reg <= since_rdy_reg + 4'h1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      hold_cnt_reg <= '0;
    else if (pend_rise && early_win && token_ready_ind)
      hold_cnt_reg <= 13'(HOLD_CYC);
    else if (send_request || !token_ready_ind)
      hold_cnt_reg <= '0;
    else if (hold_cnt_reg != '0)
      hold_cnt_reg <= hold_cnt_reg - 13'h1;
  end
  assign token_hold = (hold_cnt_reg != '0);

  // state, accept and frame end kind
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      state_reg  <= ST_IDLE;
      accept_reg <= 1'b0;
      end_reg    <= mac_tx_pkg::END_NONE;
      minpre_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      end_reg   <= mac_tx_pkg::END_NONE;
      // link abort or pass drops accept
      if (link_kill)
        accept_reg <= 1'b0;
      // abort drops accept and blocks raising
      else if (honor_abort)
        accept_reg <= 1'b0;
      // last marker drops accept next cycle
      else if (honor_last)
        accept_reg <= 1'b0;
      // raised on control byte, held per byte
      else if (start_frame)
        accept_reg <= 1'b1;
      if (state_reg == ST_DATA && honor_abort && !link_kill)
        end_reg <= mac_tx_pkg::END_SUBST;
      // honoured last only with accept high
      else if (state_reg == ST_DATA && honor_last && !link_kill)
        end_reg <= mac_tx_pkg::END_NORMAL;
      if (start_frame)
        minpre_reg <= early_win;
    end
  end
  // accept also stalls while the buffer is full
  assign byte_accept  = accept_reg & buf_in_ready;
  assign frame_end    = end_reg;
  assign min_preamble = minpre_reg;

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      class_reg <= mac_tx_pkg::CLASS_NONE;
    // final qualified by pending and stability
    else if (final_ok && request_pending)
      class_reg <= mac_tx_pkg::CLASS_ISSUE;
    else if (start_frame && class_reg == mac_tx_pkg::CLASS_NONE)
      class_reg <= mac_tx_pkg::CLASS_CAPTURE;
    else if (!token_ready_ind && state_reg == ST_IDLE)
      class_reg <= mac_tx_pkg::CLASS_NONE;
  end
  assign current_token_class = class_reg;

  // accept low one cycle after last marker
  a_last_drops: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    honor_last |=> !accept_reg)
    else $error("accept stayed high after last marker");
  a_abort_blocks: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (abort_request && !last_byte_marker) |=> !accept_reg)
    else $error("accept high during abort");
  // link abort or pass drops accept
  a_kill_drops: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    link_kill |=> !accept_reg)
    else $error("accept high after abort or pass");
  a_accept_rise: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    $rose(accept_reg) |-> $past(start_frame))
    else $error("accept rose without send");
  // abort with last gives normal end
  a_tie_last: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (state_reg == ST_DATA && honor_last && abort_request && !link_kill)
    |=> end_reg == mac_tx_pkg::END_NORMAL)
    else $error("abort not ignored with last marker");
  a_final_issue: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (final_ok && request_pending) |=> class_reg == mac_tx_pkg::CLASS_ISSUE)
    else $error("issue class not taken");
  a_final_qual: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    $changed(class_reg) && class_reg == mac_tx_pkg::CLASS_ISSUE
    |-> $past(stable_held) >= 3'h3)
    else $error("final honoured too early");
  a_min_pre: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (start_frame && since_rdy_reg < 4'h6) |=> minpre_reg)
    else $error("minimum preamble not flagged");
  a_abort_subst: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (state_reg == ST_DATA && honor_abort && !link_kill)
    |=> end_reg == mac_tx_pkg::END_SUBST)
    else $error("no substitute frame on abort");
endmodule : mac_tx_request_handshake

// ==== frame_source.sv ====
`timescale 1ns/1ps
// requester model: class code, pending, then a frame byte by byte
module frame_source (
  input  wire logic       clk_sys,
  input  wire logic       byte_accept,
  input  wire logic       stop_ind,
  output logic            request_pending,
  output logic            send_request,
  output logic            final_frame_flag,
  output logic            last_byte_marker,
  output logic            abort_request,
  output logic [7:0]      request_data_bus,
  output logic [3:0]      service_class_code
);
  // quiet lines at time zero
  initial
  begin
    {request_pending, send_request, final_frame_flag} = 3'h0;
    {last_byte_marker, abort_request} = 2'h0;
    request_data_bus   = 8'h00;
    service_class_code = 4'h0;
  end

  // mode 0 plain, 1 abort in place of byte k, 2 abort with last byte
  task automatic send_frame(input logic [7:0] d[16], input int len,
                            input int dly, input int mode, input int k);
    int i;
    int n;
    i = 1;
    n = 0;
    // code settles a cycle before pending
    @(posedge clk_sys);
    service_class_code <= d[0][3:0];
    @(posedge clk_sys);
    request_pending <= 1'h1;
    repeat (dly) @(posedge clk_sys);
    send_request     <= 1'h1;
    request_data_bus <= d[0];
    @(posedge clk_sys);
    // last marker rides the final byte
    request_data_bus <= d[1];
    last_byte_marker <= (len == 2);
    abort_request    <= (mode != 0) && (k == 1);
    // a stall holds byte and markers unchanged; bounded so no hang
    while (i < len && n < 400)
    begin
      @(posedge clk_sys);
      n++;
      if (stop_ind || (abort_request && mode == 1))
        break;
      if (byte_accept)
      begin
        i++;
        // after the final byte the release below drives the lines
        if (i < len)
        begin
          request_data_bus <= d[i];
          last_byte_marker <= (i == len - 1);
          abort_request    <= (mode != 0) && (i == k);
        end
      end
    end
    // abort held on so the bench sees accept stay down
    if (mode == 1)
      repeat (3) @(posedge clk_sys);
    // release; bus stops showing the last value
    {request_pending, send_request} <= 2'h0;
    {last_byte_marker, abort_request} <= 2'h0;
    request_data_bus <= ~request_data_bus;
  endtask : send_frame

  // final only with pending up and send low
  task automatic offer_final(input logic [3:0] code, input int settle);
    @(posedge clk_sys);
    service_class_code <= code;
    @(posedge clk_sys);
    request_pending <= 1'h1;
    repeat (settle) @(posedge clk_sys);
    final_frame_flag <= 1'h1;
    @(posedge clk_sys);
    final_frame_flag <= 1'h0;
  endtask : offer_final
endmodule : frame_source

// ==== mac_tx_request_handshake_tb_top.sv ====
`timescale 1ns/1ps
// random frames through the handshake against a stalling sink
module mac_tx_request_handshake_tb_top;
  logic       clk_sys, rstn, token_ready_ind, transmit_abort_ind;
  logic       token_pass_ind, tx_ready, tx_valid, tx_last, min_preamble;
  logic       request_pending, send_request, final_frame_flag;
  logic       last_byte_marker, abort_request, byte_accept;
  logic [7:0] request_data_bus, tx_byte;
  logic [3:0] service_class_code;
  logic [1:0] current_token_class, frame_end;
  logic [1:0] fe_seen;    // last frame end kind
  logic       mp_seen;    // preamble kind while accepting
  logic       abt_q;      // abort one cycle back
  logic       rdy_q;      // token ready one cycle back
  logic       token_hold; // hold window from the design
  logic       chk_bytes;  // off while bytes may be flushed
  logic [8:0] exp_q[$];   // {last, byte} owed by the sink
  logic       is_issue;
  int         n_fail;
  int         samples_checked;

  assign is_issue = current_token_class === mac_tx_pkg::CLASS_ISSUE;

  // short hold window keeps the run brief
  mac_tx_request_handshake #(.HOLD_CYC(20)) i_mac_tx_request_handshake (
    .clk_sys, .rstn, .request_pending, .send_request, .final_frame_flag,
    .last_byte_marker, .abort_request, .request_data_bus,
    .service_class_code, .byte_accept, .current_token_class,
    .token_ready_ind, .transmit_abort_ind, .token_pass_ind, .tx_valid,
    .tx_ready, .tx_byte, .tx_last, .frame_end, .min_preamble,
    .token_hold(token_hold));

  frame_source i_frame_source (
    .clk_sys, .byte_accept, .stop_ind(transmit_abort_ind | token_pass_ind),
    .request_pending, .send_request, .final_frame_flag, .last_byte_marker,
    .abort_request, .request_data_bus, .service_class_code);

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // a hang is cut far past the expected run length
  initial
  begin
    #200000;
    n_fail++;
    finish_test();
  end

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %0h vs %0h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    $display("checked %0d, failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  function automatic logic [8:0] end_kind(input int mode);
    return (mode == 1) ? 9'(mac_tx_pkg::END_SUBST)
                       : 9'(mac_tx_pkg::END_NORMAL);
  endfunction : end_kind

  // sink stalls one cycle in four; watches bytes and frame ends
  always @(posedge clk_sys)
  begin
    tx_ready <= ($urandom % 4) != 0;
    abt_q    <= abort_request;
    rdy_q    <= token_ready_ind;
    if (rstn && rdy_q === 1'b0)
      check(9'(token_hold), 9'h000);
    if (frame_end !== mac_tx_pkg::END_NONE)
      fe_seen <= frame_end;
    if (byte_accept === 1'b1)
      mp_seen <= min_preamble;
    if (rstn && tx_valid === 1'b1 && tx_ready && chk_bytes)
      check({tx_last, tx_byte}, exp_q.pop_front());
    if (abt_q && abort_request && !last_byte_marker)
      check(9'(byte_accept), 9'h000);
  end

  // random frame: queue what the sink owes, hand it to the model
  task automatic run_frame(input int len, input int dly, input int mode,
                           input int k);
    logic [7:0] d[16];
    foreach (d[j])
      d[j] = 8'($urandom);
    chk_bytes = (mode != 1);
    fe_seen   = mac_tx_pkg::END_NONE;
    for (int j = 0; j < len; j++)
      exp_q.push_back({j == len - 1, d[j]});
    token_ready_ind <= 1'b0;
    @(posedge clk_sys);
    token_ready_ind <= 1'b1;
    i_frame_source.send_frame(d, len, dly, mode, k);
    repeat (10) @(posedge clk_sys);
    check(9'(fe_seen), end_kind(mode));
    check(9'(mp_seen), 9'((dly + 1) < mac_tx_pkg::MIN_PRE_WIN));
    if (mode != 1)
      check(9'(exp_q.size()), 9'h000);
    exp_q.delete();
  endtask : run_frame

  // transmitter cuts the frame by abort or token pass
  task automatic cut_frame(input logic pass);
    logic [7:0] d[16];
    foreach (d[j])
      d[j] = 8'($urandom);
    chk_bytes = 1'b0;
    fork
      i_frame_source.send_frame(d, 12, 1, 0, 0);
      begin
        repeat (7) @(posedge clk_sys);
        token_pass_ind     <= pass;
        transmit_abort_ind <= !pass;
        @(posedge clk_sys);
        #1 check(9'(byte_accept), 9'h000);
        token_pass_ind     <= 1'b0;
        transmit_abort_ind <= 1'b0;
      end
    join
    repeat (10) @(posedge clk_sys);
  endtask : cut_frame

  initial
  begin
    {rstn, token_ready_ind, transmit_abort_ind, token_pass_ind} = 4'h0;
    {tx_ready, chk_bytes, abt_q, mp_seen, rdy_q} = 5'h00;
    fe_seen         = mac_tx_pkg::END_NONE;
    n_fail          = 0;
    samples_checked = 0;
    void'($urandom(32'h47E7));
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    // corners: shortest, late send, abort, abort beside last
    run_frame(2, 1, 0, 0);
    run_frame(15, 7, 0, 0);
    run_frame(8, 1, 1, 3);
    run_frame(6, 1, 2, 5);
    cut_frame(1'b0);
    cut_frame(1'b1);
    // final flag honoured once qualified, refused on a fresh code
    i_frame_source.offer_final(4'h5, 4);
    repeat (2) @(posedge clk_sys);
    #1 check(9'(is_issue), 9'h001);
    token_ready_ind <= 1'b0;
    repeat (4) @(posedge clk_sys);
    token_ready_ind <= 1'b1;
    i_frame_source.offer_final(4'hA, 0);
    repeat (2) @(posedge clk_sys);
    #1 check(9'(is_issue), 9'h000);
    i_frame_source.offer_final(4'hA, 2);
    repeat (2) @(posedge clk_sys);
    #1 check(9'(is_issue), 9'h001);
    repeat (24)
      run_frame(2 + $urandom % 14, ($urandom % 2) ? 7 : 1, 0, 0);
    finish_test();
  end
endmodule : mac_tx_request_handshake_tb_top
